// ### uii_pkg.sv
// constants shared by the interrupt identification block
`default_nettype none
package uii_pkg;
    // register select values
    localparam logic [2:0] RS_RX_BUF   = 3'h0;
    localparam logic [2:0] RS_IRQ_EN   = 3'h1;
    localparam logic [2:0] RS_IRQ_ID   = 3'h2;
    localparam logic [2:0] RS_SCRATCH  = 3'h7;

    // reset values
    localparam logic [3:0] IRQ_EN_RST  = 4'h0;
    localparam logic [7:0] SCRATCH_RST = 8'h00;

    // enable bit positions
    localparam int EN_RX_AVAIL = 0;
    localparam int EN_TX_EMPTY = 1;
    localparam int EN_LINE     = 2;
    localparam int EN_MODEM    = 3;

    // identification register field positions
    localparam int IDF_PEND    = 0;
    localparam int IDF_MODE_LO = 6;

    // identification codes, bits 3..0, bit 0 is pending_n
    localparam logic [3:0] ID_NONE    = 4'h1;
    localparam logic [3:0] ID_LINE    = 4'h6;
    localparam logic [3:0] ID_RX_AVL  = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hC;
    localparam logic [3:0] ID_TX_EMP  = 4'h2;
    localparam logic [3:0] ID_MODEM   = 4'h0;

    // mode field: character mode / fifo mode
    localparam logic [1:0] MODE_CHAR  = 2'h0;
    localparam logic [1:0] MODE_FIFO  = 2'h3;

    // receive trigger levels in bytes
    localparam logic [4:0] TRIG_LVL0  = 5'h01;
    localparam logic [4:0] TRIG_LVL1  = 5'h04;
    localparam logic [4:0] TRIG_LVL2  = 5'h08;

    // character times of silence before a timeout
    localparam int TIMEOUT_CHARS = 4;
endpackage : uii_pkg
`default_nettype wire

// ### uii_timeout_if.sv
// carrier between the identification logic and the timeout counter
`timescale 1ns/1ps
`default_nettype none
interface uii_timeout_if;
    logic tick;
    logic activity;
    logic occupied;
    logic clear;
    logic expired;

    modport owner (output tick, output activity, output occupied, output clear, input expired);
    modport timer (input tick, input activity, input occupied, input clear, output expired);
endinterface : uii_timeout_if
`default_nettype wire

// ### uii_char_timeout.sv
// receive fifo character timeout counter
`timescale 1ns/1ps
`default_nettype none
module uii_char_timeout
    import uii_pkg::*;
#(
    parameter int CHARS = TIMEOUT_CHARS
) (
    input  wire logic   clock,
    input  wire logic   arst_n,
    uii_timeout_if.timer tif
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       expired;
    } uii_tmo_state_t;

    uii_tmo_state_t st_reg;
    uii_tmo_state_t st_next;
    logic           set_evt;

    always_comb begin
        st_next = st_reg;
        set_evt = 1'b0;
        if (tif.activity || !tif.occupied) begin
            st_next.cnt = 3'h0;
        end else if (tif.tick && st_reg.cnt != 3'(CHARS)) begin
            st_next.cnt = st_reg.cnt + 3'h1;
            // expire on the tick that completes the silent interval
            set_evt     = (st_reg.cnt == 3'(CHARS - 1));
        end
        // a new expiry beats a same-cycle clear
        st_next.expired = set_evt ||
                          (st_reg.expired && !tif.clear && tif.occupied);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tif.expired = st_reg.expired;

    AST_TMO_NEEDS_SILENCE: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(st_reg.expired) |-> $past(st_reg.cnt) == 3'(CHARS - 1) && $past(tif.occupied))
        else $error("timeout raised without the full silent interval");
endmodule : uii_char_timeout
`default_nettype wire

// ### uii_irq_ident.sv
// interrupt prioritisation, identification, enable and scratch registers
`timescale 1ns/1ps
`default_nettype none
module uii_irq_ident
    import uii_pkg::*;
#(
    parameter int         CNT_W       = 5,
    parameter logic [4:0] TRIG_LVL3   = 5'h0E
) (
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             chip_sel,
    input  wire logic [2:0]       register_select,
    input  wire logic             rd_strobe,
    input  wire logic             wr_strobe,
    input  wire logic [7:0]       wr_data,
    output logic      [7:0]       rd_data,
    input  wire logic             divisor_latch_access,
    input  wire logic             fifo_mode,
    input  wire logic [1:0]       rx_trigger_level,
    input  wire logic             irq_gate,
    input  wire logic [3:0]       line_err_flags,
    input  wire logic             rx_data_ready,
    input  wire logic [CNT_W-1:0] rx_fifo_count,
    input  wire logic             rx_push,
    input  wire logic             rx_pop,
    input  wire logic             char_tick,
    input  wire logic             tx_empty,
    input  wire logic [3:0]       modem_delta,
    output logic                  irq
);
    typedef struct packed {
        logic [3:0] irq_enable_reg;
        logic [7:0] scratch_reg;
        logic [3:0] ident;
        logic       tx_flag;
        logic       tx_prev;
        logic       irq;
    } uii_state_t;

    uii_state_t st_reg;
    uii_state_t st_next;

    uii_timeout_if tmo_if ();

    logic [3:0]       eff_en;
    logic             src_line;
    logic             src_rx;
    logic             src_tmo;
    logic             src_tx;
    logic             src_modem;
    logic [3:0]       live_code;
    logic             id_addressed;
    logic             ier_sel;
    logic             rx_buf_rd;
    logic             tx_hold_wr;
    logic             id_read_tx;
    logic             tx_rise;
    logic [CNT_W-1:0] trig_bytes;

    function automatic logic [CNT_W-1:0] trig_of(input logic [1:0] sel);
        logic [4:0] lvl;
        lvl = TRIG_LVL0;
        if (sel == 2'h1) begin
            lvl = TRIG_LVL1;
        end else if (sel == 2'h2) begin
            lvl = TRIG_LVL2;
        end else if (sel == 2'h3) begin
            lvl = TRIG_LVL3;
        end
        return CNT_W'(lvl);
    endfunction : trig_of

    // fixed priority; timeout ranks second, just above data available
    function automatic logic [3:0] prio_code(input logic line, input logic tmo,
                                             input logic rx, input logic tx,
                                             input logic modem);
        logic [3:0] c;
        c = ID_NONE;
        if (line) begin
            c = ID_LINE;
        end else if (tmo) begin
            c = ID_TIMEOUT;
        end else if (rx) begin
            c = ID_RX_AVL;
        end else if (tx) begin
            c = ID_TX_EMP;
        end else if (modem) begin
            c = ID_MODEM;
        end
        return c;
    endfunction : prio_code

    // bus decode
    assign id_addressed = chip_sel && register_select == RS_IRQ_ID;
    assign ier_sel      = chip_sel && register_select == RS_IRQ_EN && !divisor_latch_access;
    assign rx_buf_rd    = chip_sel && rd_strobe && register_select == RS_RX_BUF
                          && !divisor_latch_access;
    assign tx_hold_wr   = chip_sel && wr_strobe && register_select == RS_RX_BUF
                          && !divisor_latch_access;
    assign id_read_tx   = id_addressed && rd_strobe && st_reg.ident == ID_TX_EMP;

    // timeout counter hookup, only meaningful in fifo mode
    assign tmo_if.tick     = char_tick;
    assign tmo_if.activity = rx_push || rx_pop;
    assign tmo_if.occupied = fifo_mode && rx_fifo_count != '0;
    assign tmo_if.clear    = rx_buf_rd;

    uii_char_timeout #(
        .CHARS (TIMEOUT_CHARS)
    ) u_timeout (
        .clock  (clock),
        .arst_n (arst_n),
        .tif    (tmo_if)
    );

    // the gate masks every enable, so sources keep setting but report nothing
    assign eff_en     = st_reg.irq_enable_reg & {4{irq_gate}};
    assign trig_bytes = trig_of(rx_trigger_level);
    assign src_line   = (|line_err_flags) && eff_en[EN_LINE];
    assign src_rx     = (fifo_mode ? (rx_fifo_count >= trig_bytes) : rx_data_ready)
                        && eff_en[EN_RX_AVAIL];
    assign src_tmo    = tmo_if.expired && eff_en[EN_RX_AVAIL];
    assign src_tx     = st_reg.tx_flag && eff_en[EN_TX_EMPTY];
    assign src_modem  = (|modem_delta) && eff_en[EN_MODEM];
    assign live_code  = prio_code(src_line, src_tmo, src_rx, src_tx, src_modem);
    assign tx_rise    = tx_empty && !st_reg.tx_prev;

    always_comb begin
        st_next         = st_reg;
        st_next.tx_prev = tx_empty;
        // frozen while addressed so software reads one consistent code
        if (!id_addressed) begin
            st_next.ident = live_code;
        end
        // tx empty is an event flag; a fresh empty edge beats the clear
        st_next.tx_flag = tx_rise || (st_reg.tx_flag && !tx_hold_wr && !id_read_tx);
        st_next.irq     = live_code != ID_NONE;
        if (chip_sel && wr_strobe) begin
            if (ier_sel) begin
                st_next.irq_enable_reg = wr_data[3:0];
            end else if (register_select == RS_SCRATCH) begin
                st_next.scratch_reg = wr_data;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.irq_enable_reg <= IRQ_EN_RST;
            st_reg.scratch_reg    <= SCRATCH_RST;
            st_reg.ident          <= ID_NONE;
            st_reg.tx_flag        <= 1'b0;
            st_reg.tx_prev        <= 1'b1;
            st_reg.irq            <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // read mux; identification ignores the latch bit and takes no writes
    always_comb begin
        rd_data = 8'h00;
        if (ier_sel) begin
            rd_data = {4'h0, st_reg.irq_enable_reg};
        end else if (register_select == RS_IRQ_ID) begin
            rd_data = {(fifo_mode ? MODE_FIFO : MODE_CHAR), 2'h0, st_reg.ident};
        end else if (register_select == RS_SCRATCH) begin
            rd_data = st_reg.scratch_reg;
        end
    end

    assign irq = st_reg.irq;

    AST_LINE_FIRST: assert property (@(posedge clock) disable iff (!arst_n)
        (src_line && !id_addressed) |=> st_reg.ident == ID_LINE)
        else $error("line status not reported at top priority");

    AST_FREEZE: assert property (@(posedge clock) disable iff (!arst_n)
        id_addressed |=> $stable(st_reg.ident))
        else $error("identification changed while addressed");

    AST_ID_READ_ONLY: assert property (@(posedge clock) disable iff (!arst_n)
        (id_addressed && wr_strobe) |=> $stable(st_reg.irq_enable_reg)
                                        && $stable(st_reg.scratch_reg))
        else $error("write at identification select changed a register");

    AST_ID_LAYOUT: assert property (@(posedge clock) disable iff (!arst_n)
        (register_select == RS_IRQ_ID) |-> rd_data[5:4] == 2'h0
            && rd_data[7:IDF_MODE_LO] == (fifo_mode ? MODE_FIFO : MODE_CHAR)
            && rd_data[IDF_PEND] == (st_reg.ident == ID_NONE))
        else $error("identification read layout wrong");

    AST_IER_WRITE: assert property (@(posedge clock) disable iff (!arst_n)
        (ier_sel && wr_strobe) |=> st_reg.irq_enable_reg == $past(wr_data[3:0])
            ##1 (!ier_sel || rd_data[7:4] == 4'h0))
        else $error("enable register write lost");

    AST_IER_LATCHED: assert property (@(posedge clock) disable iff (!arst_n)
        (chip_sel && wr_strobe && register_select == RS_IRQ_EN && divisor_latch_access)
            |=> $stable(st_reg.irq_enable_reg))
        else $error("enable register written under latch access");

    AST_GATE_OFF: assert property (@(posedge clock) disable iff (!arst_n)
        (!irq_gate && !id_addressed) |=> st_reg.ident == ID_NONE && !irq)
        else $error("interrupt reported with output gate clear");

    AST_TX_CLEAR: assert property (@(posedge clock) disable iff (!arst_n)
        (tx_hold_wr && !tx_rise) |=> !st_reg.tx_flag)
        else $error("holding write did not clear tx empty");

    AST_SCRATCH: assert property (@(posedge clock) disable iff (!arst_n)
        (chip_sel && wr_strobe && register_select == RS_SCRATCH)
            |=> st_reg.scratch_reg == $past(wr_data) && $stable(st_reg.irq_enable_reg))
        else $error("scratch write lost or leaked");
endmodule : uii_irq_ident
`default_nettype wire

// ### uii_host_model.sv
// host cpu model driving the register port of the identification block
`timescale 1ns/1ps
`default_nettype none
module uii_host_model (
    input  wire logic       clock,
    output logic            chip_sel,
    output logic [2:0]      register_select,
    output logic            rd_strobe,
    output logic            wr_strobe,
    output logic [7:0]      wr_data,
    input  wire logic [7:0] rd_data
);
    initial begin
        chip_sel = 1'b0;
        register_select = 3'h0;
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
    end

    // one access held for n edges; read data taken at the last edge
    task automatic access(input logic [2:0] sel, input logic wr, input logic [7:0] d,
                          input int n, output logic [7:0] q);
        @(negedge clock);
        chip_sel = 1'b1;
        register_select = sel;
        rd_strobe = ~wr;
        wr_strobe = wr;
        wr_data = d;
        repeat (n) @(posedge clock);
        q = rd_data;
        @(negedge clock);
        chip_sel = 1'b0;
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        // released lines flip so stale values never look valid
        register_select = ~sel;
        wr_data = ~d;
    endtask : access
endmodule : uii_host_model
`default_nettype wire

// ### uii_irq_ident_tb_top.sv
// self-checking testbench of the interrupt identification block
`timescale 1ns/1ps
`default_nettype none
module uii_irq_ident_tb_top;
    import uii_pkg::*;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       chip_sel, rd_strobe, wr_strobe, irq;
    logic [2:0] register_select;
    logic [7:0] wr_data, rd_data, q;
    logic       divisor_latch_access = 1'b0, fifo_mode = 1'b0, irq_gate = 1'b0;
    logic [1:0] rx_trigger_level = 2'h0;
    logic [3:0] line_err_flags = 4'h0, modem_delta = 4'h0;
    logic       rx_data_ready = 1'b0, rx_push = 1'b0, rx_pop = 1'b0;
    logic       char_tick = 1'b0, tx_empty = 1'b1;
    logic [4:0] rx_fifo_count = 5'h00;
    // last entry mirrors the default of the block's fourth trigger level parameter
    logic [4:0] trig [4] = '{TRIG_LVL0, TRIG_LVL1, TRIG_LVL2, 5'h0E};
    int         error_cnt = 0, num_checks = 0;

    always #25 clock = ~clock;

    uii_irq_ident u_dut (.clock(clock), .arst_n(arst_n), .chip_sel(chip_sel),
        .register_select(register_select), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_data(rd_data), .divisor_latch_access(divisor_latch_access),
        .fifo_mode(fifo_mode), .rx_trigger_level(rx_trigger_level), .irq_gate(irq_gate),
        .line_err_flags(line_err_flags), .rx_data_ready(rx_data_ready),
        .rx_fifo_count(rx_fifo_count), .rx_push(rx_push), .rx_pop(rx_pop),
        .char_tick(char_tick), .tx_empty(tx_empty), .modem_delta(modem_delta), .irq(irq));

    uii_host_model u_host (.clock(clock), .chip_sel(chip_sel),
        .register_select(register_select), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .rd_data(rd_data));

    function automatic logic [7:0] id(input logic [3:0] code);
        return {(fifo_mode ? MODE_FIFO : MODE_CHAR), 2'h0, code};
    endfunction : id

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [2:0] sel, input logic [7:0] exp);
        u_host.access(sel, 1'b0, 8'h00, 1, q);
        chk(q, exp);
    endtask : rd_chk

    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        u_host.access(sel, 1'b1, d, 1, q);
    endtask : wr

    // two edges: one for the live code, one for the ident register
    task automatic settle;
        repeat (2) @(negedge clock);
    endtask : settle

    task automatic pulse_tx;
        tx_empty = 1'b0;
        @(negedge clock);
        tx_empty = 1'b1;
        settle();
    endtask : pulse_tx

    task automatic t_reset;
        rd_chk(RS_IRQ_EN, 8'h00);
        rd_chk(RS_IRQ_ID, id(ID_NONE));
        chk({7'h00, irq}, 8'h00);
    endtask : t_reset

    task automatic t_regs;
        wr(RS_IRQ_EN, 8'hFF);
        rd_chk(RS_IRQ_EN, 8'h0F);
        divisor_latch_access = 1'b1;
        wr(RS_IRQ_EN, 8'h00);
        wr(RS_SCRATCH, 8'hA5);
        rd_chk(RS_SCRATCH, 8'hA5);
        divisor_latch_access = 1'b0;
        rd_chk(RS_IRQ_EN, 8'h0F);
        wr(RS_IRQ_ID, 8'hFF);
        rd_chk(RS_IRQ_ID, id(ID_NONE));
    endtask : t_regs

    task automatic t_prio;
        irq_gate = 1'b1;
        line_err_flags = 4'h2;
        rx_data_ready = 1'b1;
        modem_delta = 4'h1;
        pulse_tx();
        rd_chk(RS_IRQ_ID, id(ID_LINE));
        chk({7'h00, irq}, 8'h01);
        line_err_flags = 4'h0;
        settle();
        rd_chk(RS_IRQ_ID, id(ID_RX_AVL));
        rx_data_ready = 1'b0;
        settle();
        rd_chk(RS_IRQ_ID, id(ID_TX_EMP));
        settle();
        rd_chk(RS_IRQ_ID, id(ID_MODEM));
        modem_delta = 4'h0;
        pulse_tx();
        chk({7'h00, irq}, 8'h01);
        wr(RS_RX_BUF, 8'h00);
        settle();
        rd_chk(RS_IRQ_ID, id(ID_NONE));
        chk({7'h00, irq}, 8'h00);
    endtask : t_prio

    task automatic t_mask;
        line_err_flags = 4'h8;
        wr(RS_IRQ_EN, 8'h0B);
        settle();
        rd_chk(RS_IRQ_ID, id(ID_NONE));
        wr(RS_IRQ_EN, 8'h0F);
        irq_gate = 1'b0;
        settle();
        rd_chk(RS_IRQ_ID, id(ID_NONE));
        chk({7'h00, irq}, 8'h00);
        line_err_flags = 4'h0;
        irq_gate = 1'b1;
    endtask : t_mask

    task automatic t_freeze;
        fork
            u_host.access(RS_IRQ_ID, 1'b0, 8'h00, 3, q);
            begin
                @(negedge clock);
                line_err_flags = 4'h1;
            end
        join
        chk(q, id(ID_NONE));
        settle();
        rd_chk(RS_IRQ_ID, id(ID_LINE));
        line_err_flags = 4'h0;
    endtask : t_freeze

    task automatic t_fifo;
        fifo_mode = 1'b1;
        rx_trigger_level = 2'h1;
        rx_fifo_count = 5'h02;
        rx_push = 1'b1;
        @(negedge clock);
        rx_push = 1'b0;
        for (int i = 1; i <= 4; i++) begin
            char_tick = 1'b1;
            @(negedge clock);
            char_tick = 1'b0;
            settle();
            rd_chk(RS_IRQ_ID, id(i == 4 ? ID_TIMEOUT : ID_NONE));
        end
        rd_chk(RS_RX_BUF, 8'h00);
        settle();
        rd_chk(RS_IRQ_ID, id(ID_NONE));
        for (int l = 0; l < 4; l++) begin
            rx_trigger_level = 2'(l);
            rx_fifo_count = trig[l] - 5'h01;
            settle();
            rd_chk(RS_IRQ_ID, id(ID_NONE));
            rx_fifo_count = trig[l];
            settle();
            rd_chk(RS_IRQ_ID, id(ID_RX_AVL));
        end
    endtask : t_fifo

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #(50 * 5000);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        t_reset();
        t_regs();
        t_prio();
        t_mask();
        t_freeze();
        t_fifo();
        tally_and_finish();
    end
endmodule : uii_irq_ident_tb_top
`default_nettype wire
